// *** src/mplc_media_pulse_line_codec.sv ***
// media pulse line codec: pulse encoder, receive slicer, strap and wishbone registers
`timescale 1ns/1ns
module mplc_media_pulse_line_codec
  import mplc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tx_bit_valid,
  input  wire logic        tx_bit,
  output logic             tx_bit_ready,
  output logic             rx_bit_valid,
  output logic             rx_bit,
  input  wire logic        rx_line_in,
  output logic             tx_pulse_primary_n,
  output logic             tx_pulse_primary_oe,
  input  wire logic        tx_pulse_secondary_in,
  output logic             tx_pulse_secondary_n,
  output logic             tx_pulse_secondary_oe,
  output logic             line_drive_enable,
  output logic             line_drive_enable_oe
);
  localparam int A_HYB_M1 = HYB_PULSE_CYC - 1;
  localparam int A_BP     = BP_PULSE_CYC;
  localparam int A_BP_M1  = BP_PULSE_CYC - 1;

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return {adr[7:2], 2'b00} == ofs;
  endfunction

  logic rst_meta_ff;
  logic rst_n_ff;
  logic rx_sync;
  logic sec_sync;
  logic rx_busy;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  mplc_sync #(.RST_VAL(1'b0)) u_rx_sync (
    .clk   (sys_clk),
    .rst_n (rst_n_ff),
    .d     (rx_line_in),
    .q     (rx_sync)
  );

  mplc_sync #(.RST_VAL(1'b1)) u_strap_sync (
    .clk   (sys_clk),
    .rst_n (rst_n_ff),
    .d     (tx_pulse_secondary_in),
    .q     (sec_sync)
  );

  // strap: pin is left undriven until the polarity has been caught
  logic [1:0] strap_wait_ff;
  logic [1:0] nxt_strap_wait;
  logic       strap_ok_ff;
  logic       nxt_strap_ok;
  logic       strap_hi_ff;
  logic       nxt_strap_hi;

  always_comb
  begin
    nxt_strap_wait = strap_wait_ff;
    nxt_strap_ok   = strap_ok_ff;
    nxt_strap_hi   = strap_hi_ff;
    if (!strap_ok_ff)
    begin
      if (strap_wait_ff == 2'(STRAP_WAIT_CYC - 1))
      begin
        nxt_strap_ok = 1'b1;
        nxt_strap_hi = ~sec_sync;
      end
      else
        nxt_strap_wait = strap_wait_ff + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      strap_wait_ff <= '0;
      strap_ok_ff   <= 1'b0;
      strap_hi_ff   <= 1'b0;
    end
    else
    begin
      strap_wait_ff <= nxt_strap_wait;
      strap_ok_ff   <= nxt_strap_ok;
      strap_hi_ff   <= nxt_strap_hi;
    end
  end

  // wishbone slave: ack one cycle after the strobe, unmapped reads give zero
  logic       ack_ff;
  logic       nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic       bp_ff;
  logic       nxt_bp;
  logic       pp_ff;
  logic       nxt_pp;
  logic       line_drive_enable_ff;
  logic       nxt_line_drive_enable;
  logic [1:0] rate_ff;
  logic [1:0] nxt_rate;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic       wb_go;

  mplc_tx_st_t      tx_st_ff;
  logic             tx_bit_ff;
  logic             rate_err;
  logic             drive_on;

  assign wb_go = wb_cyc_i & wb_stb_i & ~ack_ff;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[CTRL_BP_BIT]   = bp_ff;
    ctrl_word[CTRL_PP_BIT]   = pp_ff;
    ctrl_word[CTRL_LINE_DRIVE_ENABLE_BIT] = line_drive_enable_ff;
    ctrl_word[CTRL_RATE_LSB +: 2] = rate_ff;
    stat_word = '0;
    stat_word[STAT_STRAP_HI_BIT] = strap_hi_ff;
    stat_word[STAT_STRAP_OK_BIT] = strap_ok_ff;
    stat_word[STAT_TX_BUSY_BIT]  = (tx_st_ff == TX_SEND);
    stat_word[STAT_RATE_ERR_BIT] = rate_err;
    stat_word[STAT_RX_ACT_BIT]   = rx_busy;
  end

  always_comb
  begin
    nxt_ack  = wb_go;
    nxt_dat  = dat_ff;
    nxt_bp   = bp_ff;
    nxt_pp   = pp_ff;
    nxt_line_drive_enable = line_drive_enable_ff;
    nxt_rate = rate_ff;
    if (wb_go)
    begin
      if (wb_we_i)
      begin
        if (reg_hit(wb_adr_i, REG_CTRL_OFS) && wb_sel_i[0])
        begin
          nxt_bp   = wb_dat_i[CTRL_BP_BIT];
          nxt_pp   = wb_dat_i[CTRL_PP_BIT];
          nxt_line_drive_enable = wb_dat_i[CTRL_LINE_DRIVE_ENABLE_BIT];
          nxt_rate = wb_dat_i[CTRL_RATE_LSB +: 2];
        end
      end
      else if (reg_hit(wb_adr_i, REG_CTRL_OFS))
        nxt_dat = ctrl_word;
      else if (reg_hit(wb_adr_i, REG_STAT_OFS))
        nxt_dat = stat_word;
      else
        nxt_dat = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      ack_ff  <= 1'b0;
      dat_ff  <= '0;
      bp_ff   <= CTRL_RST[CTRL_BP_BIT];
      pp_ff   <= CTRL_RST[CTRL_PP_BIT];
      line_drive_enable_ff <= CTRL_RST[CTRL_LINE_DRIVE_ENABLE_BIT];
      rate_ff <= CTRL_RST[CTRL_RATE_LSB +: 2];
    end
    else
    begin
      ack_ff  <= nxt_ack;
      dat_ff  <= nxt_dat;
      bp_ff   <= nxt_bp;
      pp_ff   <= nxt_pp;
      line_drive_enable_ff <= nxt_line_drive_enable;
      rate_ff <= nxt_rate;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // transmit encoder; pads are registered from the next state so the pulse
  // edges line up exactly with the bit counter
  mplc_tx_st_t      nxt_tx_st;
  logic [CNT_W-1:0] tx_cnt_ff;
  logic [CNT_W-1:0] nxt_tx_cnt;
  logic             nxt_tx_bit;
  logic [CNT_W-1:0] len;
  logic [CNT_W-1:0] half;
  logic             tx_ok;
  logic             tx_last;
  logic             pri_act;
  logic             sec_act;
  logic             od_mode;
  logic             pri_n_ff;
  logic             pri_oe_ff;
  logic             sec_n_ff;
  logic             sec_oe_ff;
  logic             en_ff;
  logic             en_oe_ff;
  logic             nxt_pri_n;
  logic             nxt_pri_oe;
  logic             nxt_sec_oe;
  logic             nxt_en;

  assign len      = mplc_bit_len(rate_ff);
  assign half     = len >> 1;
  assign rate_err = ~bp_ff & (rate_ff != RATE_2M5);
  assign drive_on = line_drive_enable_ff & strap_ok_ff;
  assign tx_ok    = drive_on & ~rate_err;
  assign tx_last  = (tx_st_ff == TX_SEND) && (tx_cnt_ff == len - CNT_W'(1));
  assign tx_bit_ready = tx_ok & ((tx_st_ff == TX_IDLE) | tx_last);
  assign od_mode  = bp_ff & ~pp_ff;

  always_comb
  begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    if (!tx_ok)
    begin
      nxt_tx_st  = TX_IDLE;
      nxt_tx_cnt = '0;
      nxt_tx_bit = 1'b0;
    end
    else if (tx_bit_valid && tx_bit_ready)
    begin
      nxt_tx_st  = TX_SEND;
      nxt_tx_cnt = '0;
      nxt_tx_bit = tx_bit;
    end
    else if (tx_last)
    begin
      nxt_tx_st  = TX_IDLE;
      nxt_tx_cnt = '0;
    end
    else if (tx_st_ff == TX_SEND)
      nxt_tx_cnt = tx_cnt_ff + CNT_W'(1);
    pri_act = (nxt_tx_st == TX_SEND) && nxt_tx_bit
      && (bp_ff ? nxt_tx_cnt < half : nxt_tx_cnt < CNT_W'(HYB_PULSE_CYC));
    if (bp_ff)
      sec_act = (nxt_tx_st == TX_SEND) && nxt_tx_cnt < half;
    else
      sec_act = (nxt_tx_st == TX_SEND) && nxt_tx_bit
        && nxt_tx_cnt >= CNT_W'(HYB_PULSE_CYC)
        && nxt_tx_cnt < CNT_W'(HYB_PULSE_CYC) + CNT_W'(HYB_PULSE_CYC);
    nxt_pri_oe = od_mode ? pri_act : 1'b1;
    nxt_pri_n  = od_mode ? 1'b0 : ~pri_act;
    // a grounded strap pin must never see the clock driven onto it
    nxt_sec_oe = strap_ok_ff & (~bp_ff | ~strap_hi_ff);
    nxt_en     = (bp_ff & strap_hi_ff) ? drive_on : ~drive_on;
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      tx_st_ff  <= TX_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= 1'b0;
      pri_n_ff  <= 1'b1;
      pri_oe_ff <= 1'b0;
      sec_n_ff  <= 1'b1;
      sec_oe_ff <= 1'b0;
      en_ff     <= 1'b1;
      en_oe_ff  <= 1'b0;
    end
    else
    begin
      tx_st_ff  <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      pri_n_ff  <= nxt_pri_n;
      pri_oe_ff <= nxt_pri_oe;
      sec_n_ff  <= ~sec_act;
      sec_oe_ff <= nxt_sec_oe;
      en_ff     <= nxt_en;
      en_oe_ff  <= strap_ok_ff;
    end
  end

  assign tx_pulse_primary_n    = pri_n_ff;
  assign tx_pulse_primary_oe   = pri_oe_ff;
  assign tx_pulse_secondary_n  = sec_n_ff;
  assign tx_pulse_secondary_oe = sec_oe_ff;
  assign line_drive_enable     = en_ff;
  assign line_drive_enable_oe  = en_oe_ff;

  mplc_rx_slicer u_rx (
    .clk         (sys_clk),
    .rst_n       (rst_n_ff),
    .line        (rx_sync),
    .active_high (~bp_ff),
    .bit_len     (len),
    .bit_valid   (rx_bit_valid),
    .bit_out     (rx_bit),
    .busy        (rx_busy)
  );

  logic pri_low;
  assign pri_low = tx_pulse_primary_oe & ~tx_pulse_primary_n;

  reset_lines_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    $rose(rst_n_ff) |-> tx_pulse_primary_n && !tx_pulse_primary_oe
    && !tx_pulse_secondary_oe && !line_drive_enable_oe && !pp_ff)
    else $error("lines not idle after reset");
  hyb_pri_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    !bp_ff && tx_ok && $fell(tx_pulse_primary_n)
    |-> ##A_HYB_M1 !tx_pulse_primary_n ##1 tx_pulse_primary_n)
    else $error("hybrid primary pulse width wrong");
  hyb_sec_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    !bp_ff && tx_st_ff == TX_SEND && $rose(tx_pulse_primary_n)
    |-> $fell(tx_pulse_secondary_n) ##A_HYB_M1 !tx_pulse_secondary_n)
    else $error("hybrid secondary pulse missing");
  hyb_no_overlap_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    !bp_ff && $stable(bp_ff) |-> tx_pulse_primary_n || tx_pulse_secondary_n)
    else $error("hybrid pulses overlap");
  hyb_zero_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    !bp_ff && $stable(bp_ff) && tx_st_ff == TX_SEND && !tx_bit_ff
    |-> tx_pulse_primary_n && tx_pulse_secondary_n)
    else $error("pulse during hybrid zero");
  hyb_rate_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    !bp_ff && rate_ff != RATE_2M5 |-> !tx_bit_ready ##1 tx_st_ff == TX_IDLE)
    else $error("hybrid send at wrong rate");
  od_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    od_mode && $past(od_mode) && tx_pulse_primary_oe
    |-> !tx_pulse_primary_n && tx_st_ff == TX_SEND && tx_bit_ff)
    else $error("open drain drives outside a pulse");
  bp_pulse_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    bp_ff && rate_ff == RATE_2M5 && tx_ok && $rose(pri_low)
    |-> ##A_BP_M1 pri_low ##1 !pri_low)
    else $error("backplane pulse width wrong");
  drive_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    pri_low |-> line_drive_enable_oe
    && line_drive_enable == (bp_ff && strap_hi_ff))
    else $error("pulse without drive enable");
  bp_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    bp_ff && rate_ff == RATE_2M5 && tx_ok && $fell(tx_pulse_secondary_n)
    |-> ##A_BP tx_pulse_secondary_n)
    else $error("backplane data clock period wrong");
  strap_pick_a: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    $rose(strap_ok_ff) |-> strap_hi_ff == !$past(sec_sync) ##1
    (!(bp_ff && strap_hi_ff) || !tx_pulse_secondary_oe))
    else $error("strap polarity capture wrong");
endmodule // mplc_media_pulse_line_codec

// *** src/mplc_pkg.sv ***
// shared constants, register map and types of the media pulse line codec
package mplc_pkg;

  localparam int CLK_MHZ      = 250;
  localparam int BIT_TIME_NS  = 400;
  localparam int HYB_PULSE_NS = 100;
  localparam int BP_PULSE_NS  = 200;
  localparam int RX_TOL_NS    = 100;

  localparam int BIT_CYC       = (BIT_TIME_NS * CLK_MHZ) / 1000;
  localparam int HYB_PULSE_CYC = (HYB_PULSE_NS * CLK_MHZ) / 1000;
  localparam int BP_PULSE_CYC  = (BP_PULSE_NS * CLK_MHZ) / 1000;
  localparam int RX_TOL_CYC    = (RX_TOL_NS * CLK_MHZ) / 1000;

  localparam int CNT_W          = 8;
  localparam int STRAP_WAIT_CYC = 3;
  localparam int RX_IDLE_BITS   = 8;

  localparam logic [7:0]  REG_CTRL_OFS = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS = 8'h04;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  localparam int CTRL_BP_BIT   = 0;
  localparam int CTRL_PP_BIT   = 1;
  localparam int CTRL_LINE_DRIVE_ENABLE_BIT = 2;
  localparam int CTRL_RATE_LSB = 4;

  localparam int STAT_STRAP_HI_BIT  = 0;
  localparam int STAT_STRAP_OK_BIT  = 1;
  localparam int STAT_TX_BUSY_BIT   = 2;
  localparam int STAT_RATE_ERR_BIT  = 3;
  localparam int STAT_RX_ACT_BIT    = 4;

  localparam logic [1:0] RATE_2M5 = 2'h0;
  localparam logic [1:0] RATE_5M  = 2'h1;

  typedef enum logic {TX_IDLE, TX_SEND} mplc_tx_st_t;
  typedef enum logic {RX_IDLE, RX_RUN} mplc_rx_st_t;

  // cycles in one bit period for a rate code
  function automatic logic [CNT_W-1:0] mplc_bit_len(input logic [1:0] rate);
    logic [CNT_W-1:0] len;
    case (rate)
      RATE_2M5: len = CNT_W'(BIT_CYC);
      RATE_5M:  len = CNT_W'(BIT_CYC / 2);
      default:  len = CNT_W'(BIT_CYC / 4);
    endcase
    return len;
  endfunction

endpackage

// *** src/mplc_sync.sv ***
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ns
module mplc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // mplc_sync

// *** src/mplc_rx_slicer.sv ***
// receive pulse slicer: pulses on the line into a windowed nrz bit stream
`timescale 1ns/1ns
module mplc_rx_slicer
  import mplc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             line,
  input  wire logic             active_high,
  input  wire logic [CNT_W-1:0] bit_len,
  output logic                  bit_valid,
  output logic                  bit_out,
  output logic                  busy
);
  localparam int A_LO = BIT_CYC - RX_TOL_CYC;
  localparam int A_HI = BIT_CYC + RX_TOL_CYC;

  mplc_rx_st_t      st_ff;
  mplc_rx_st_t      nxt_st;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [2:0]       zeros_ff;
  logic [2:0]       nxt_zeros;
  logic             lvl_ff;
  logic             bv_ff;
  logic             nxt_bv;
  logic             b_ff;
  logic             nxt_b;
  logic             lvl;
  logic             edge_hit;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] limit;

  assign lvl      = active_high ? line : ~line;
  assign edge_hit = lvl & ~lvl_ff;
  assign half     = bit_len >> 1;
  assign limit    = bit_len + half - CNT_W'(1);

  // window of one bit period centred on the expected pulse, so a pulse may
  // wander half a bit either way before it lands in the wrong bit
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_zeros = zeros_ff;
    nxt_bv    = 1'b0;
    nxt_b     = b_ff;
    case (st_ff)
      RX_IDLE:
      begin
        if (edge_hit)
        begin
          nxt_st    = RX_RUN;
          nxt_cnt   = '0;
          nxt_zeros = '0;
          nxt_bv    = 1'b1;
          nxt_b     = 1'b1;
        end
      end
      RX_RUN:
      begin
        if (edge_hit && cnt_ff >= half)
        begin
          nxt_cnt   = '0;
          nxt_zeros = '0;
          nxt_bv    = 1'b1;
          nxt_b     = 1'b1;
        end
        else if (cnt_ff == limit)
        begin
          nxt_cnt = half;
          nxt_bv  = 1'b1;
          nxt_b   = 1'b0;
          if (zeros_ff == 3'(RX_IDLE_BITS - 1))
            nxt_st = RX_IDLE;
          else
            nxt_zeros = zeros_ff + 3'h1;
        end
        else
          nxt_cnt = cnt_ff + CNT_W'(1);
      end
      default:
        nxt_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff    <= RX_IDLE;
      cnt_ff   <= '0;
      zeros_ff <= '0;
      lvl_ff   <= 1'b0;
      bv_ff    <= 1'b0;
      b_ff     <= 1'b0;
    end
    else
    begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      zeros_ff <= nxt_zeros;
      lvl_ff   <= lvl;
      bv_ff    <= nxt_bv;
      b_ff     <= nxt_b;
    end
  end

  assign bit_valid = bv_ff;
  assign bit_out   = b_ff;
  assign busy      = (st_ff == RX_RUN);

  rx_first_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == RX_IDLE && edge_hit |=> bit_valid && bit_out)
    else $error("first pulse not taken as a one");
  rx_jitter_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == RX_RUN && edge_hit && bit_len == CNT_W'(BIT_CYC)
    && cnt_ff >= CNT_W'(A_LO) && cnt_ff <= CNT_W'(A_HI) |=> bit_valid && bit_out)
    else $error("displaced pulse lost");
  rx_zero_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == RX_RUN && !edge_hit && cnt_ff == limit |=> bit_valid && !bit_out)
    else $error("missing pulse not taken as a zero");
endmodule // mplc_rx_slicer

// *** tb/mplc_line_model.sv ***
// far side of the media port: line pull-ups, board strap and receive path
`timescale 1ns/1ns
module mplc_line_model (
  input  wire logic prim_n,
  input  wire logic prim_oe,
  input  wire logic sec_n,
  input  wire logic sec_oe,
  input  wire logic backplane,
  input  wire logic strap_gnd,
  input  wire logic inj,
  output logic      prim_wire,
  output logic      sec_wire,
  output logic      rx_line
);
  // one pull-up on the media brings a released line back high
  assign prim_wire = prim_oe ? prim_n : 1'b1;
  // a grounding strap stays in place for good, not only during power-on
  assign sec_wire = strap_gnd ? 1'b0 : (sec_oe ? sec_n : 1'b1);
  // hybrid hands the dipulse on as a positive pulse; backplane ties rx to the line
  assign rx_line = backplane ? (prim_wire & ~inj) : (inj | ~prim_wire);
endmodule // mplc_line_model

// *** tb/test_media_pulse_line_codec.sv ***
// self-checking bench of the media pulse line codec
`timescale 1ns/1ns
module test_media_pulse_line_codec;
  import mplc_pkg::*;
  logic        sys_clk, nrst, cyc, stb, we, tv, tbit, inj, bp, gnd, mclr;
  logic        ack, rdy, rv, rb, pn, poe, sn, soe, en, en_oe, pw, sw, rxl;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rdo;
  int          n_fail, num_checks, pf, sf;
  // 0 primary low, 1 secondary low, 2 primary oe, 3 overlap, 4 enable wrong,
  // 5 rx ones, 6 rx zeros, 7 cycles since clear
  int          k [8];
  int          gap [4] = '{125, 75, 75, 60};

  mplc_media_pulse_line_codec mplc_media_pulse_line_codec_i (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .tx_bit_valid(tv), .tx_bit(tbit),
    .tx_bit_ready(rdy), .rx_bit_valid(rv), .rx_bit(rb), .rx_line_in(rxl),
    .tx_pulse_primary_n(pn), .tx_pulse_primary_oe(poe),
    .tx_pulse_secondary_in(sw), .tx_pulse_secondary_n(sn),
    .tx_pulse_secondary_oe(soe), .line_drive_enable(en),
    .line_drive_enable_oe(en_oe)
  );

  mplc_line_model mplc_line_model_i (
    .prim_n(pn), .prim_oe(poe), .sec_n(sn), .sec_oe(soe), .backplane(bp),
    .strap_gnd(gnd), .inj(inj), .prim_wire(pw), .sec_wire(sw), .rx_line(rxl)
  );

  always #2 sys_clk = ~sys_clk;

  // counts are taken from pre-edge values, so they match the registered pads
  always @(posedge sys_clk)
  begin
    if (mclr)
    begin
      k  <= '{default: 0};
      pf <= -1;
      sf <= -1;
    end
    else
    begin
      k[0] <= k[0] + int'(pw === 1'b0);
      k[1] <= k[1] + int'(sw === 1'b0);
      k[2] <= k[2] + int'(poe === 1'b1);
      k[3] <= k[3] + int'(pw === 1'b0 && sw === 1'b0);
      k[4] <= k[4] + int'(bp && pw === 1'b0 && (en !== gnd || en_oe !== 1'b1));
      k[5] <= k[5] + int'(rv === 1'b1 && rb === 1'b1);
      k[6] <= k[6] + int'(rv === 1'b1 && rb === 1'b0);
      k[7] <= k[7] + 1;
      if (pw === 1'b0 && pf < 0)
        pf <= k[7];
      if (sw === 1'b0 && sf < 0)
        sf <= k[7];
    end
  end

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      chk(1'b0, "wait timed out");
      print_verdict();
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    tmo(ack);
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  // offers one bit, clears the counters, then watches the whole bit period
  task automatic xmit(input logic b);
    int i;
    tv   <= 1'b1;
    tbit <= b;
    mclr <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      mclr <= 1'b0;
      i++;
    end
    while (rdy !== 1'b1 && i < 400);
    tmo(rdy);
    tv <= 1'b0;
    // one edge more so the counters hold the last cycle of the bit as well
    repeat (BIT_CYC + 1) @(posedge sys_clk);
  endtask

  // a mode change swaps the idle level of the receive line, which the
  // receiver takes as a pulse; wait until it has run out its zeros
  task automatic rx_quiet();
    int i;
    i = 0;
    do
    begin
      wb(1'b0, REG_STAT_OFS, 32'h0);
      i++;
    end
    while (rdat[STAT_RX_ACT_BIT] !== 1'b0 && i < 400);
    tmo(!rdat[STAT_RX_ACT_BIT]);
  endtask

  task automatic do_reset(input logic g);
    int i;
    gnd  <= g;
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(pn === 1'b1 && poe === 1'b0 && sn === 1'b1 && soe === 1'b0 && en_oe === 1'b0,
        "pads active in reset");
    nrst <= 1'b1;
    i = 0;
    do
    begin
      wb(1'b0, REG_STAT_OFS, 32'h0);
      i++;
    end
    while (rdat[STAT_STRAP_OK_BIT] !== 1'b1 && i < 20);
    tmo(rdat[STAT_STRAP_OK_BIT]);
    chk(rdat[STAT_STRAP_HI_BIT] === g, "strap polarity");
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rdat === CTRL_RST, "control reset value");
  endtask

  initial
  begin
    {sys_clk, nrst, cyc, stb, we, tv, tbit, inj, bp, gnd, mclr} = '0;
    {adr, wdat, n_fail, num_checks} = '0;
    sel = 4'h1;
    do_reset(1'b0);
    wb(1'b1, 8'h08, 32'h0000_00ff);
    wb(1'b0, 8'h08, 32'h0);
    chk(rdat === 32'h0, "unmapped read");
    wb(1'b1, REG_CTRL_OFS, 32'h0000_0004);
    xmit(1'b1);
    chk(k[0] === HYB_PULSE_CYC && k[1] === HYB_PULSE_CYC && k[3] === 0, "hybrid one");
    chk(sf - pf === HYB_PULSE_CYC, "pulse order");
    chk(k[5] === 1, "hybrid receive one");
    xmit(1'b0);
    chk(k[0] === 0 && k[1] === 0, "hybrid zero");
    wb(1'b1, REG_CTRL_OFS, 32'h0000_0014);
    wb(1'b0, REG_STAT_OFS, 32'h0);
    chk(rdat[STAT_RATE_ERR_BIT] === 1'b1 && rdy === 1'b0, "hybrid at 5M");
    bp <= 1'b1;
    wb(1'b1, REG_CTRL_OFS, 32'h0000_0015);
    wb(1'b0, REG_STAT_OFS, 32'h0);
    chk(rdat[STAT_RATE_ERR_BIT] === 1'b0 && rdy === 1'b1, "backplane at 5M");
    rx_quiet();
    wb(1'b1, REG_CTRL_OFS, 32'h0000_0005);
    xmit(1'b1);
    chk(k[0] === BP_PULSE_CYC && k[2] === BP_PULSE_CYC, "open drain one");
    chk(k[4] === 0, "enable during pulse");
    chk(k[1] === BIT_CYC / 2 && sf === 0, "data clock");
    chk(k[5] === 1, "backplane receive one");
    xmit(1'b0);
    chk(k[0] === 0 && k[2] === 0 && k[1] === BIT_CYC / 2, "open drain zero");
    wb(1'b1, REG_CTRL_OFS, 32'h0000_0007);
    xmit(1'b0);
    chk(k[0] === 0 && k[2] === BIT_CYC, "push-pull zero");
    xmit(1'b1);
    chk(k[0] === BP_PULSE_CYC && k[4] === 0, "push-pull one");
    // long silence first so the receiver has gone idle before the burst
    bp <= 1'b0;
    wb(1'b1, REG_CTRL_OFS, 32'h0);
    rx_quiet();
    mclr <= 1'b1;
    @(posedge sys_clk);
    mclr <= 1'b0;
    foreach (gap[j])
    begin
      inj <= 1'b1;
      repeat (10) @(posedge sys_clk);
      inj <= 1'b0;
      repeat (gap[j] - 10) @(posedge sys_clk);
    end
    chk(k[5] === 4 && k[6] === 0, "displaced pulses");
    repeat (100) @(posedge sys_clk);
    chk(k[5] === 4 && k[6] === 1, "missing pulse not a zero");
    do_reset(1'b1);
    bp <= 1'b1;
    wb(1'b1, REG_CTRL_OFS, 32'h0000_0005);
    xmit(1'b1);
    chk(k[0] === BP_PULSE_CYC && k[4] === 0 && soe === 1'b0, "active-high enable");
    print_verdict();
  end
endmodule // test_media_pulse_line_codec
